// file: ssm_cfg.svh
/*
 shifter state machine: register offsets, field positions, reset values.
 assumes a 12-bit byte address on the plain register port.
*/
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
`define SSM_ENABLE_OFS 12'h000
`define SSM_STATE_OFS 12'h004
`define SSM_FLAGS_OFS 12'h008
`define SSM_IRQ_STATUS_OFS 12'h00c
`define SSM_IRQ_MASK_OFS 12'h010
`define SSM_CTRL_BASE 12'h080
`define SSM_CFG_BASE 12'h100
`define SSM_BUF_BASE 12'h200
`define SSM_CTRL_MODE_LSB 0
`define SSM_CTRL_POL_BIT 7
`define SSM_CTRL_PIN_SELECT_FIELD_LSB 8
`define SSM_CTRL_TIMER_SELECT_FIELD_LSB 24
`define SSM_CFG_START_LSB 0
`define SSM_CFG_STOP_LSB 4
`define SSM_CFG_INPUT_SOURCE_FIELD_BIT 8
`define SSM_CFG_WIDTH_LSB 16
`define SSM_CTRL_MASK 32'h07001f87
`define SSM_CFG_MASK 32'h000f0133
`define SSM_REG_RESET 32'h00000000
`define SSM_PTR_RESET 3'h0
`endif

// file: ssm_pkg.sv
/*
 shifter state machine: shared types.
 assumes nothing beyond the compiler.
*/
package ssm_pkg;
   typedef enum logic [2:0] {
      SSM_DISABLED,
      SSM_RECEIVE,
      SSM_TRANSMIT,
      SSM_RESERVED,
      SSM_MATCH_STORE,
      SSM_MATCH_CONT,
      SSM_STATE,
      SSM_LOGIC
   } ssm_mode_t;
   typedef logic [2:0] ssm_ptr_t;
endpackage : ssm_pkg

// file: ssm_shifter.sv
/*
 one shifter: its control, configuration and buffer registers, input
 selection and next-state lookup. assumes writes come pre-decoded.
*/
`timescale 1ns/100ps
`include "ssm_cfg.svh"
module ssm_shifter import ssm_pkg::*; #(
   parameter int PINS = 32
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic wr_ctrl,
   input wire logic wr_cfg,
   input wire logic wr_buf,
   input wire logic [31:0] wdata,
   input wire logic [PINS-1:0] pins_in,
   input wire logic [2:0] next_lsb,
   output logic [31:0] ctrl_q,
   output logic [31:0] cfg_q,
   output logic [31:0] buf_q,
   output ssm_ptr_t next_state,
   output logic [7:0] out_en,
   output ssm_mode_t mode,
   output logic [2:0] timer_sel
);
   localparam int PSW = $clog2(PINS);
   logic [31:0] ctrl_d;
   logic [31:0] cfg_d;
   logic [31:0] buf_d;
   logic [2:0] pin_bits;
   logic [2:0] sel;
   logic [PSW-1:0] base;
   int idx;

   always_comb begin
      idx = 0;
      ctrl_d = wr_ctrl ? (wdata & `SSM_CTRL_MASK) : ctrl_q;
      cfg_d = wr_cfg ? (wdata & `SSM_CFG_MASK) : cfg_q;
      buf_d = wr_buf ? wdata : buf_q;
      mode = ssm_mode_t'(ctrl_q[`SSM_CTRL_MODE_LSB +: 3]); // see [RQ7] see [RQ8]
      timer_sel = ctrl_q[`SSM_CTRL_TIMER_SELECT_FIELD_LSB +: 3];
      base = ctrl_q[`SSM_CTRL_PIN_SELECT_FIELD_LSB +: PSW];
      // pin window wraps past the top pin rather than reading off the end
      for (int k = 0; k < 3; k++) begin
         idx = int'(base) + k;
         if (idx >= PINS) begin
            idx = idx - PINS;
         end
         pin_bits[k] = pins_in[idx] ^ ctrl_q[`SSM_CTRL_POL_BIT]; // see [RQ3] see [RQ4]
      end
      sel = cfg_q[`SSM_CFG_INPUT_SOURCE_FIELD_BIT] ? next_lsb : pin_bits; // see [RQ3]
      next_state = buf_q[3 * int'(sel) +: 3]; // see [RQ15] see [RQ16]
      out_en = ~{cfg_q[`SSM_CFG_WIDTH_LSB +: 4], cfg_q[`SSM_CFG_STOP_LSB +: 2],
                 cfg_q[`SSM_CFG_START_LSB +: 2]}; // see [RQ6]
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ctrl_q <= `SSM_REG_RESET;
         cfg_q <= `SSM_REG_RESET;
         buf_q <= `SSM_REG_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         cfg_q <= cfg_d;
         buf_q <= buf_d;
      end
   end
endmodule : ssm_shifter

// file: ssm_state_machine.sv
/*
 shifter state machine top: eight shifters, state pointer, output pins,
 status flags, interrupt, and the plain register port.
 assumes synchronous pins and one-cycle timer expiry pulses.
*/
// What this block does
// [RQ1] up to eight states, one per shifter set to state mode
// [RQ2] each state reads three input bits and drives eight outputs
// [RQ3] inputs from three pins at pin select, or shifter n+1 low bits
// [RQ4] pin inputs pass through the pin polarity setting first
// [RQ5] all states drive the same eight output pins 0 to 7
// [RQ6] width, stop and start field bits disable individual outputs
// [RQ7] mode field bits 2 to 0; 110b selects state mode
// [RQ8] other mode codes decode to their listed modes
// [RQ9] pointer defines active state when enabled; resets to zero
// [RQ10] software should set the pointer first if shifter 0 is not a state
// [RQ11] pointer field bits 2 to 0 names the driving shifter
// [RQ12] writing the pointer replaces the current state at once
// [RQ13] a pointer read during an update may be stale
// [RQ14] outputs carry the top byte of the current shifter buffer
// [RQ15] low 24 buffer bits are eight three-bit next-state codes
// [RQ16] input value n picks next-state group n
// [RQ17] pointer moves only when the selected timer expires
// [RQ18] a shifter's flag is high while the pointer selects it
// [RQ19] pointer and pins change on the expiry clock edge
`timescale 1ns/100ps
`include "ssm_cfg.svh"
module ssm_state_machine import ssm_pkg::*; #(
   parameter int PINS = 32,
   parameter int NSHIFT = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [PINS-1:0] pins_in,
   input wire logic [NSHIFT-1:0] timer_expire,
   output logic [7:0] state_output_pins,
   output logic [7:0] state_output_en,
   output logic [NSHIFT-1:0] state_flags,
   output logic irq
);
   logic [31:0] ctrl_w [NSHIFT];
   logic [31:0] cfg_w [NSHIFT];
   logic [31:0] buf_w [NSHIFT];
   ssm_ptr_t next_w [NSHIFT];
   logic [7:0] outen_w [NSHIFT];
   ssm_mode_t mode_w [NSHIFT];
   logic [2:0] tsel_w [NSHIFT];
   logic [NSHIFT-1:0] wr_ctrl;
   logic [NSHIFT-1:0] wr_cfg;
   logic [NSHIFT-1:0] wr_buf;

   logic en_q;
   logic en_d;
   ssm_ptr_t ptr_q;
   ssm_ptr_t ptr_d;
   logic [7:0] pins_q;
   logic [7:0] pins_d;
   logic [7:0] oen_q;
   logic [7:0] oen_d;
   logic [NSHIFT-1:0] flag_q;
   logic [NSHIFT-1:0] flag_d;
   logic [NSHIFT-1:0] ist_q;
   logic [NSHIFT-1:0] ist_d;
   logic [NSHIFT-1:0] mask_q;
   logic [NSHIFT-1:0] mask_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   logic st_wr;
   logic adv;
   logic cur_state;
   logic nxt_state;
   ssm_ptr_t next_sel;
   logic [31:0] cur_buf;
   logic [NSHIFT-1:0] flag_rise;

   // eight registers of one kind share a 32-byte window
   function automatic logic win_hit(input logic [11:0] a, input logic [11:0] b);
      win_hit = (a[11:5] == b[11:5]);
   endfunction : win_hit

   function automatic int win_idx(input logic [11:0] a);
      win_idx = int'(a[4:2]);
   endfunction : win_idx

   always_comb begin
      wr_ctrl = '0;
      wr_cfg = '0;
      wr_buf = '0;
      if (reg_wr && win_hit(reg_addr, `SSM_CTRL_BASE)) begin
         wr_ctrl[win_idx(reg_addr)] = 1'b1;
      end else if (reg_wr && win_hit(reg_addr, `SSM_CFG_BASE)) begin
         wr_cfg[win_idx(reg_addr)] = 1'b1;
      end else if (reg_wr && win_hit(reg_addr, `SSM_BUF_BASE)) begin
         wr_buf[win_idx(reg_addr)] = 1'b1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NSHIFT; gi++) begin : g_sh
         ssm_shifter #(
            .PINS(PINS)
         ) u_sh (
            .clock(clock),
            .reset(reset),
            .wr_ctrl(wr_ctrl[gi]),
            .wr_cfg(wr_cfg[gi]),
            .wr_buf(wr_buf[gi]),
            .wdata(reg_wdata),
            .pins_in(pins_in),
            .next_lsb(buf_w[(gi + 1) % NSHIFT][2:0]), // see [RQ3]
            .ctrl_q(ctrl_w[gi]),
            .cfg_q(cfg_w[gi]),
            .buf_q(buf_w[gi]),
            .next_state(next_w[gi]),
            .out_en(outen_w[gi]),
            .mode(mode_w[gi]),
            .timer_sel(tsel_w[gi])
         );
      end
   endgenerate

   // state pointer, pins and flags
   always_comb begin
      st_wr = reg_wr && (reg_addr == `SSM_STATE_OFS);
      cur_state = en_q && (mode_w[ptr_q] == SSM_STATE); // see [RQ1] see [RQ9]
      cur_buf = buf_w[ptr_q];
      next_sel = next_w[ptr_q];
      adv = cur_state && timer_expire[tsel_w[ptr_q]]; // see [RQ17]
      en_d = en_q;
      if (reg_wr && (reg_addr == `SSM_ENABLE_OFS)) begin
         en_d = reg_wdata[0];
      end
      // a software write beats a timer step landing in the same cycle
      ptr_d = ptr_q;
      if (st_wr) begin
         ptr_d = reg_wdata[2:0]; // see [RQ12]
      end else if (adv) begin
         ptr_d = next_sel; // see [RQ16] see [RQ19]
      end
      nxt_state = en_d && (mode_w[ptr_d] == SSM_STATE);
      pins_d = 8'h00;
      oen_d = 8'h00;
      if (nxt_state) begin
         pins_d = buf_w[ptr_d][31:24]; // see [RQ14] see [RQ5] see [RQ19]
         oen_d = outen_w[ptr_d]; // see [RQ6]
      end
      flag_d = '0;
      if (nxt_state) begin
         flag_d[ptr_d] = 1'b1; // see [RQ18]
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         en_q <= 1'b0;
         ptr_q <= `SSM_PTR_RESET; // see [RQ9]
         pins_q <= 8'h00;
         oen_q <= 8'h00;
         flag_q <= '0;
      end else begin
         en_q <= en_d;
         ptr_q <= ptr_d;
         pins_q <= pins_d;
         oen_q <= oen_d;
         flag_q <= flag_d;
      end
   end

   // interrupt: entering a state is the event
   always_comb begin
      flag_rise = flag_d & ~flag_q;
      ist_d = ist_q;
      mask_d = mask_q;
      if (reg_wr && (reg_addr == `SSM_IRQ_STATUS_OFS)) begin
         ist_d = ist_q & ~reg_wdata[NSHIFT-1:0];
      end
      if (reg_wr && (reg_addr == `SSM_IRQ_MASK_OFS)) begin
         mask_d = reg_wdata[NSHIFT-1:0];
      end
      // set wins over a clear in the same cycle
      ist_d = ist_d | flag_rise;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         ist_q <= '0;
         mask_q <= '0;
      end else begin
         ist_q <= ist_d;
         mask_q <= mask_d;
      end
   end

   // read port: data stand only in the cycle after the strobe
   // the pointer reads as registered, so a read beside a step shows the old state
   always_comb begin
      rdata_d = 32'h00000000;
      if (!reg_rd) begin
         rdata_d = 32'h00000000;
      end else if (reg_addr == `SSM_ENABLE_OFS) begin
         rdata_d[0] = en_q;
      end else if (reg_addr == `SSM_STATE_OFS) begin
         rdata_d[2:0] = ptr_q; // see [RQ11] see [RQ13]
      end else if (reg_addr == `SSM_FLAGS_OFS) begin
         rdata_d[NSHIFT-1:0] = flag_q;
      end else if (reg_addr == `SSM_IRQ_STATUS_OFS) begin
         rdata_d[NSHIFT-1:0] = ist_q;
      end else if (reg_addr == `SSM_IRQ_MASK_OFS) begin
         rdata_d[NSHIFT-1:0] = mask_q;
      end else if (win_hit(reg_addr, `SSM_CTRL_BASE)) begin
         rdata_d = ctrl_w[win_idx(reg_addr)];
      end else if (win_hit(reg_addr, `SSM_CFG_BASE)) begin
         rdata_d = cfg_w[win_idx(reg_addr)];
      end else if (win_hit(reg_addr, `SSM_BUF_BASE)) begin
         rdata_d = buf_w[win_idx(reg_addr)];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign state_output_pins = pins_q;
   assign state_output_en = oen_q;
   assign state_flags = flag_q;
   assign irq = |(ist_q & mask_q);

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   ptr_write_a : assert property ( // see [RQ12]
      st_wr |=> ptr_q == $past(reg_wdata[2:0])
   ) else $error("pointer write not taken");

   ptr_hold_a : assert property ( // see [RQ17]
      (!adv && !st_wr) |=> $stable(ptr_q)
   ) else $error("pointer moved without timer expiry");

   ptr_step_a : assert property ( // see [RQ16]
      (adv && !st_wr) |=> ptr_q == $past(next_sel)
   ) else $error("pointer took wrong next state");

   pins_byte_a : assert property ( // see [RQ14]
      (cur_state && $past(cur_state) && $stable(ptr_q) && $stable(cur_buf))
         |-> state_output_pins == cur_buf[31:24]
   ) else $error("output pins differ from buffer top byte");

   flag_onehot_a : assert property ( // see [RQ18]
      (state_flags != '0) |-> ($onehot(state_flags) && state_flags[ptr_q])
   ) else $error("status flag not tied to pointer");

   ptr_reset_a : assert property ( // see [RQ9]
      @(posedge clock) disable iff (1'b0) $past(reset) |-> ptr_q == 3'h0
   ) else $error("pointer not zero after reset");

   irq_set_a : assert property (
      (|flag_rise) |=> ((ist_q & $past(flag_rise)) == $past(flag_rise))
   ) else $error("state entry did not set status");

   ptr_read_a : assert property ( // see [RQ11]
      (reg_rd && reg_addr == `SSM_STATE_OFS) |=> reg_rdata == {29'h0, $past(ptr_q)}
   ) else $error("pointer read wrong");

   idle_pins_a : assert property ( // see [RQ2]
      !en_q |=> (state_output_pins == 8'h00 && state_output_en == 8'h00)
   ) else $error("outputs driven while disabled");
endmodule : ssm_state_machine

// file: ssm_timer_model.sv
/*
 far side model: the input pins and the timer units of the state machine.
 assumes the bench asks for an expiry by a one-cycle start pulse.
*/
`timescale 1ns/100ps
module ssm_timer_model #(
   parameter int PINS = 32
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic [2:0] timer,
   input wire logic [3:0] lag,
   input wire logic [PINS-1:0] pin_word,
   output logic [PINS-1:0] pins_in,
   output logic [7:0] timer_expire
);
   logic [3:0] count_q;
   logic [2:0] timer_q;
   logic armed_q;
   // pins are plain synchronous levels, changed only after an edge
   assign pins_in = pin_word;
   always_ff @(posedge clock) begin
      timer_expire <= 8'h00;
      if (reset) begin
         armed_q <= 1'b0;
         count_q <= 4'h0;
         timer_q <= 3'h0;
      end else if (start) begin
         armed_q <= 1'b1;
         count_q <= lag;
         timer_q <= timer;
      end else if (armed_q && count_q == 4'h0) begin
         // a timer unit reports its expiry as one pulse, never a level
         timer_expire <= 8'h01 << timer_q;
         armed_q <= 1'b0;
      end else if (armed_q) begin
         count_q <= count_q - 4'h1;
      end
   end
endmodule : ssm_timer_model

// file: tb.sv
/*
 self-checking bench of the shifter state machine.
 assumes the register map and timing of the design hand-over.
*/
`timescale 1ns/100ps
`include "ssm_cfg.svh"
module tb import ssm_pkg::*;;
   logic clock, reset, reg_wr, reg_rd, irq, start, peek, rd_seen, peek_seen;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, pins_in, pin_word;
   logic [7:0] timer_expire, state_output_pins, state_output_en, state_flags;
   logic [2:0] timer, ptr, v, nx, k;
   logic [3:0] lag;
   logic [31:0] ctl[8], cfg[8], bufw[8], w;
   logic [31:0] exp_q[$];
   int fails, tests_run;
   ssm_state_machine #(.PINS(32), .NSHIFT(8)) ssm_state_machine_i (.clock(clock),
      .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins_in(pins_in),
      .timer_expire(timer_expire), .state_output_pins(state_output_pins),
      .state_output_en(state_output_en), .state_flags(state_flags), .irq(irq));
   ssm_timer_model #(.PINS(32)) ssm_timer_model_i (.clock(clock), .reset(reset),
      .start(start), .timer(timer), .lag(lag), .pin_word(pin_word), .pins_in(pins_in),
      .timer_expire(timer_expire));
   always #12.5 clock = ~clock;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] e);
      tests_run++;
      if (seen !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, seen);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clock) begin
      rd_seen <= reg_rd;
      peek_seen <= peek;
   end
   // results are taken where settled, half a cycle after they stand
   always @(negedge clock) begin
      if (rd_seen === 1'b1 || peek_seen === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("queue", 32'h1, 32'h0);
         end else if (rd_seen === 1'b1) begin
            check("read data", reg_rdata, exp_q.pop_front());
         end else begin
            check("outputs", {7'h00, irq, state_flags, state_output_en,
               state_output_pins}, exp_q.pop_front());
         end
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic look(input logic [31:0] e);
      @(posedge clock);
      peek <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      peek <= 1'b0;
   endtask : look
   // the wait covers the given lag plus the registered outputs
   task automatic step(input logic [2:0] t, input logic [3:0] l);
      @(posedge clock);
      start <= 1'b1;
      timer <= t;
      lag <= l;
      @(posedge clock);
      start <= 1'b0;
      repeat (l + 4) @(posedge clock);
   endtask : step
   function automatic logic [31:0] outw(input logic [2:0] p, input logic q);
      return {7'h00, q, 8'h01 << p, ~{cfg[p][19:16], cfg[p][5:4], cfg[p][1:0]},
         bufw[p][31:24]};
   endfunction : outw
   function automatic logic [2:0] inval(input int n);
      logic [2:0] r;
      for (int i = 0; i < 3; i++) r[i] = pin_word[(ctl[n][12:8] + i) % 32] ^ ctl[n][7];
      if (cfg[n][8]) r = bufw[(n + 1) % 8][2:0];
      return r;
   endfunction : inval
   initial begin
      repeat (100000) @(posedge clock);
      check("watchdog", 32'h1, 32'h0);
      tally_and_finish();
   end
   initial begin
      {clock, reg_wr, reg_rd, start, peek, reg_addr, reg_wdata, timer, lag} = '0;
      reset = 1'b1;
      pin_word = 32'h0;
      foreach (cfg[i]) cfg[i] = 32'h0;
      void'($urandom(32'hb1d4));
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      for (int a = 0; a < 5; a++) rd(12'(4 * a), 32'h0);
      rd(12'hffc, 32'h0);
      wr(`SSM_ENABLE_OFS, 32'h1);
      bufw[0] = 32'h5a249249;
      wr(`SSM_BUF_BASE, bufw[0]);
      for (int m = 0; m < 8; m++) begin
         wr(`SSM_CTRL_BASE, 32'(m));
         rd(`SSM_CTRL_BASE, 32'(m));
         look(m == 6 ? outw(0, 0) : 32'h0);
         step(3'h0, 4'h0);
         rd(`SSM_STATE_OFS, m == 6 ? 32'h1 : 32'h0);
         wr(`SSM_STATE_OFS, 32'h0);
      end
      for (int n = 0; n < 8; n++) begin
         w = ($urandom & 32'hfffffff8) | 32'h6;
         ctl[n] = w & `SSM_CTRL_MASK;
         cfg[n] = $urandom & `SSM_CFG_MASK;
         bufw[n] = $urandom;
         wr(`SSM_CTRL_BASE + 12'(4 * n), w);
         wr(`SSM_CFG_BASE + 12'(4 * n), $urandom | cfg[n]);
         rd(`SSM_CTRL_BASE + 12'(4 * n), ctl[n]);
         wr(`SSM_BUF_BASE + 12'(4 * n), bufw[n]);
      end
      for (int n = 0; n < 8; n++) wr(`SSM_CFG_BASE + 12'(4 * n), cfg[n]);
      ptr = 3'h0;
      wr(`SSM_STATE_OFS, 32'h0);
      for (int s = 0; s < 40; s++) begin
         @(posedge clock);
         pin_word <= $urandom;
         @(posedge clock);
         v = inval(ptr);
         nx = bufw[ptr][3 * v +: 3];
         step(ctl[ptr][26:24] + 3'h1, 4'h0);
         rd(`SSM_STATE_OFS, 32'(ptr));
         step(ctl[ptr][26:24], 4'($urandom % 3));
         ptr = nx;
         rd(`SSM_STATE_OFS, 32'(ptr));
         look(outw(ptr, 1'b0));
      end
      wr(`SSM_IRQ_STATUS_OFS, 32'hff);
      rd(`SSM_IRQ_STATUS_OFS, 32'h0);
      k = ptr + 3'h3;
      wr(12'hffc, 32'h7);
      wr(`SSM_STATE_OFS, 32'(k));
      look(outw(k, 1'b0));
      rd(`SSM_IRQ_STATUS_OFS, 32'h1 << k);
      wr(`SSM_IRQ_MASK_OFS, 32'hff);
      look(outw(k, 1'b1));
      wr(`SSM_IRQ_STATUS_OFS, 32'h1 << k);
      rd(`SSM_IRQ_STATUS_OFS, 32'h0);
      look(outw(k, 1'b0));
      wr(`SSM_ENABLE_OFS, 32'h0);
      look(32'h0);
      repeat (3) @(posedge clock);
      tally_and_finish();
   end
endmodule : tb
